/* logic/tpg_checker.sv */
/*
 * self-synchronising pattern checker: prbs7, prbs31 or 64-bit user pattern.
 * assumes data_in is one received bit per enabled clock on ref_clk.
 */
`timescale 1ns/1ps
module tpg_checker import tpg_pkg::*; #(
   parameter logic [40:0] LEN1 = LEN_SHORT,
   parameter logic [40:0] LEN2 = LEN_MID,
   parameter logic [40:0] LEN3 = LEN_LONG
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   // configuration
   input wire logic [2:0] mode,
   input wire logic invert,
   input wire logic sync_mask,
   input wire logic [1:0] tb,
   input wire logic restart,
   input wire logic [63:0] user_pattern_word,
   // data and status
   input wire logic data_in,
   output tpg_chk_stat_s stat
);
   typedef enum logic [1:0] {CHK_IDLE, CHK_HUNT, CHK_LOCK, CHK_DONE} tpg_chk_e;
   tpg_chk_e st_q, st_d;
   logic [30:0] hist_q, hist_d;
   logic [5:0] run_q, run_d, idx_q, idx_d;
   logic [2:0] bad_q, bad_d;
   logic [40:0] cnt_q, cnt_d, len;
   logic ever_q, ever_d, loss_q, loss_d, err_q, err_d;
   logic b, exp_bit, match;

   always_comb begin
      b = data_in ^ invert ^ (mode == MODE_PRBS31);
      exp_bit = (mode == MODE_USER) ? user_pattern_word[idx_q] : prbs_fb(hist_q, mode);
      match = (b == exp_bit);
      case (tb)
         TB_SHORT: len = LEN1;
         TB_MID: len = LEN2;
         default: len = LEN3;
      endcase
      st_d = st_q;
      hist_d = {hist_q[29:0], b};
      idx_d = idx_q + 6'h1;
      run_d = run_q;
      bad_d = bad_q;
      cnt_d = cnt_q;
      ever_d = ever_q;
      loss_d = 1'b0;
      err_d = 1'b0;
      case (st_q)
         CHK_IDLE: begin
            run_d = 6'h0;
            if (mode != MODE_OFF) begin
               st_d = CHK_HUNT;
            end
         end
         CHK_HUNT: begin
            if (match) begin
               run_d = run_q + 6'h1;
               if (run_q == SYNC_RUN - 6'h1) begin
                  st_d = CHK_LOCK;
                  ever_d = 1'b1;
                  cnt_d = 41'h0;
                  run_d = 6'h0;
                  bad_d = 3'h0;
               end
            end else begin
               run_d = 6'h0;
               idx_d = (b == user_pattern_word[0]) ? 6'h1 : 6'h0;
            end
         end
         CHK_LOCK: begin
            cnt_d = cnt_q + 41'h1;
            if (!match) begin
               err_d = 1'b1;
               run_d = 6'h0;
               bad_d = bad_q + 3'h1;
               if (bad_q == LOSS_ERRS - 3'h1) begin
                  bad_d = 3'h0;
                  if (!(sync_mask && ever_q)) begin
                     loss_d = 1'b1;
                     st_d = CHK_HUNT;
                  end
               end
            end else if (run_q == CLEAN_RUN) begin
               bad_d = 3'h0;
            end else begin
               run_d = run_q + 6'h1;
            end
            if (tb != TB_CONT && cnt_q == len - 41'h1) begin
               // the finished check wins over a loss seen on its last bit
               st_d = CHK_DONE;
               loss_d = 1'b0;
            end
         end
         default: begin
            cnt_d = cnt_q;
         end
      endcase
      if (mode == MODE_OFF || restart) begin
         st_d = CHK_IDLE;
         loss_d = 1'b0;
         err_d = 1'b0;
         ever_d = 1'b0;
         cnt_d = 41'h0;
         bad_d = 3'h0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q <= CHK_IDLE;
         hist_q <= 31'h0;
         idx_q <= 6'h0;
         run_q <= 6'h0;
         bad_q <= 3'h0;
         cnt_q <= 41'h0;
         ever_q <= 1'b0;
         loss_q <= 1'b0;
         err_q <= 1'b0;
      end else if (ce) begin
         st_q <= st_d;
         hist_q <= hist_d;
         idx_q <= idx_d;
         run_q <= run_d;
         bad_q <= bad_d;
         cnt_q <= cnt_d;
         ever_q <= ever_d;
         loss_q <= loss_d;
         err_q <= err_d;
      end
   end

   assign stat = '{synced: st_q == CHK_LOCK, sync_loss: loss_q, error: err_q,
                   done: st_q == CHK_DONE};

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_loss_goes_hunt: assert property (loss_q |-> st_q == CHK_HUNT)
      else $error("sync loss without return to hunt");
   a_mask_holds_lock: assert property (
      ce && !restart && mode != MODE_OFF && sync_mask && ever_q && st_q == CHK_LOCK
      |=> !loss_q) else $error("masked checker reported sync loss");
   a_done_no_errors: assert property (
      st_q == CHK_DONE && $past(st_q) == CHK_DONE |-> !err_q)
      else $error("error accumulated after check length ended");
   a_len_reaches_done: assert property (
      ce && !restart && mode != MODE_OFF && st_q == CHK_LOCK && tb == TB_SHORT
      && cnt_q == LEN1 - 41'h1 |=> st_q == CHK_DONE) else $error("short length not ended");
   a_off_goes_idle: assert property (ce && mode == MODE_OFF |=> st_q == CHK_IDLE)
      else $error("disabled checker not idle");

   c_lock: cover property (st_q == CHK_HUNT ##1 st_q == CHK_LOCK);
   c_loss: cover property (loss_q);
   c_done: cover property (st_q == CHK_DONE);
endmodule

/* logic/tpg_pkg.sv */
/*
 * shared constants, types and helpers for the transmit test pattern block.
 * assumes an 8-bit management register port and one serial bit per enabled clock.
 */
package tpg_pkg;
   localparam logic [7:0] SEL_ADDR = 8'h9d;
   localparam logic [7:0] CFG_ADDR = 8'h9e;
   localparam logic [7:0] SEL_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'h02;
   localparam logic [7:0] CFG_WMASK = 8'h07;
   localparam int CHK_INV_BIT = 7;
   localparam int CHK_MODE_LSB = 4;
   localparam int GEN_INV_BIT = 3;
   localparam int GEN_MODE_LSB = 0;
   localparam int SYNC_MASK_BIT = 2;
   localparam int TB_LSB = 0;
   // hits in a row needed to lock, errors that drop lock, clean run that forgives errors
   localparam logic [5:0] SYNC_RUN = 6'h20;
   localparam logic [2:0] LOSS_ERRS = 3'h4;
   localparam logic [5:0] CLEAN_RUN = 6'h10;
   localparam logic [40:0] LEN_SHORT = (41'h1 << 20) - 41'h400;
   localparam logic [40:0] LEN_MID = (41'h1 << 30) - 41'h400;
   localparam logic [40:0] LEN_LONG = (41'h1 << 40) - 41'h400;

   typedef enum logic [2:0] {
      MODE_OFF = 3'h0,
      MODE_PRBS7 = 3'h1,
      MODE_PRBS31 = 3'h2,
      MODE_USER = 3'h3
   } tpg_mode_e;

   typedef enum logic [1:0] {
      TB_CONT = 2'h0,
      TB_SHORT = 2'h1,
      TB_MID = 2'h2,
      TB_LONG = 2'h3
   } tpg_tb_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tpg_reg_req_s;

   typedef struct packed {
      logic synced;
      logic sync_loss;
      logic error;
      logic done;
   } tpg_chk_stat_s;

   // feedback of prbs7 (x7+x6+1) or prbs31 (x31+x28+1) from a history register
   function automatic logic prbs_fb(input logic [30:0] s, input logic [2:0] mode);
      if (mode == MODE_PRBS7) begin
         return s[6] ^ s[5];
      end
      return s[30] ^ s[27];
   endfunction
endpackage

/* logic/tpg_top.sv */
/*
 * transmit test pattern generator and checker with its two control registers.
 * assumes the management port and the serial data path run on ref_clk.
 */
`timescale 1ns/1ps
module tpg_top import tpg_pkg::*; #(
   parameter logic [40:0] LEN1 = LEN_SHORT,
   parameter logic [40:0] LEN2 = LEN_MID,
   parameter logic [40:0] LEN3 = LEN_LONG
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   // management registers
   input tpg_reg_req_s reg_req,
   output logic [7:0] reg_rdata_q,
   // user pattern from its own registers
   input wire logic [63:0] user_pattern_word,
   // transmit data path
   input wire logic tx_data_in,
   output logic tx_data_out_q,
   // checker data and status
   input wire logic chk_data_in,
   output tpg_chk_stat_s chk_stat
);
   logic [7:0] sel_q, sel_d, cfg_q, cfg_d, rdata_d;
   logic [30:0] lfsr_q, lfsr_d;
   logic [5:0] idx_q, idx_d;
   logic [2:0] gen_mode;
   logic tx_d, gen_raw, restart;

   // register group
   always_comb begin
      sel_d = sel_q;
      cfg_d = cfg_q;
      rdata_d = reg_rdata_q;
      restart = 1'b0;
      if (reg_req.wr) begin
         if (reg_req.addr == SEL_ADDR) begin
            sel_d = reg_req.wdata;
            restart = 1'b1;
         end else if (reg_req.addr == CFG_ADDR) begin
            cfg_d = reg_req.wdata & CFG_WMASK;
            restart = 1'b1;
         end
      end
      if (reg_req.rd) begin
         if (reg_req.addr == SEL_ADDR) begin
            rdata_d = sel_q;
         end else if (reg_req.addr == CFG_ADDR) begin
            rdata_d = cfg_q;
         end else begin
            rdata_d = 8'h00;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sel_q <= SEL_RESET;
         cfg_q <= CFG_RESET;
         reg_rdata_q <= 8'h00;
      end else if (ce) begin
         sel_q <= sel_d;
         cfg_q <= cfg_d;
         reg_rdata_q <= rdata_d;
      end
   end

   // generator group
   assign gen_mode = sel_q[GEN_MODE_LSB +: 3];

   always_comb begin
      lfsr_d = lfsr_q;
      idx_d = 6'h0;
      case (gen_mode)
         MODE_PRBS7: begin
            gen_raw = prbs_fb(lfsr_q, gen_mode);
            lfsr_d = {lfsr_q[29:0], gen_raw};
         end
         MODE_PRBS31: begin
            gen_raw = ~prbs_fb(lfsr_q, gen_mode);
            lfsr_d = {lfsr_q[29:0], ~gen_raw};
         end
         MODE_USER: begin
            gen_raw = user_pattern_word[idx_q];
            idx_d = idx_q + 6'h1;
         end
         default: begin
            gen_raw = 1'b0;
            // reseed while off so prbs7 restarts from a live state
            lfsr_d = {31{1'b1}};
         end
      endcase
      if (gen_mode == MODE_OFF || gen_mode > MODE_USER) begin
         tx_d = tx_data_in;
      end else begin
         tx_d = gen_raw ^ sel_q[GEN_INV_BIT];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lfsr_q <= {31{1'b1}};
         idx_q <= 6'h0;
         tx_data_out_q <= 1'b0;
      end else if (ce) begin
         lfsr_q <= lfsr_d;
         idx_q <= idx_d;
         tx_data_out_q <= tx_d;
      end
   end

   tpg_checker #(
      .LEN1(LEN1),
      .LEN2(LEN2),
      .LEN3(LEN3)
   ) u_chk (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .mode(sel_q[CHK_MODE_LSB +: 3]),
      .invert(sel_q[CHK_INV_BIT]),
      .sync_mask(cfg_q[SYNC_MASK_BIT]),
      .tb(cfg_q[TB_LSB +: 2]),
      .restart(restart && ce),
      .user_pattern_word(user_pattern_word),
      .data_in(chk_data_in),
      .stat(chk_stat)
   );

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_cfg_reserved_zero: assert property (cfg_q[7:3] == 5'h00)
      else $error("reserved config bits not zero");
   a_cfg_reset_value: assert property ($past(rst) |-> cfg_q == CFG_RESET)
      else $error("config register reset value wrong");
   a_gen_off_pass: assert property (ce && gen_mode == MODE_OFF |=>
      tx_data_out_q == $past(tx_data_in)) else $error("disabled generator altered data");
   a_prbs7_taps: assert property (ce && gen_mode == MODE_PRBS7 |=>
      tx_data_out_q == ($past(lfsr_q[6] ^ lfsr_q[5]) ^ $past(sel_q[GEN_INV_BIT])))
      else $error("prbs7 output bit wrong");
   a_prbs31_polarity: assert property (ce && gen_mode == MODE_PRBS31 && !sel_q[GEN_INV_BIT] |=>
      tx_data_out_q == !$past(lfsr_q[30] ^ lfsr_q[27]))
      else $error("prbs31 polarity wrong");
   a_user_lsb_first: assert property (
      ce && gen_mode != MODE_USER ##1 ce && gen_mode == MODE_USER |=>
      tx_data_out_q == ($past(user_pattern_word[0]) ^ $past(sel_q[GEN_INV_BIT])))
      else $error("user pattern not started at bit 0");
   a_sel_readback: assert property (ce && reg_req.rd && !reg_req.wr && reg_req.addr == SEL_ADDR
      |=> reg_rdata_q == sel_q) else $error("pattern_select readback wrong");
   a_cfg_write_mask: assert property (ce && reg_req.wr && reg_req.addr == CFG_ADDR |=>
      cfg_q == ($past(reg_req.wdata) & CFG_WMASK)) else $error("config write not masked");
   a_user_next_bit: assert property (ce && gen_mode == MODE_USER |=>
      tx_data_out_q == ($past(user_pattern_word[idx_q]) ^ $past(sel_q[GEN_INV_BIT])))
      else $error("user pattern bit out of order");
   a_ce_freezes: assert property (!ce |=> $stable(sel_q) && $stable(cfg_q)
      && $stable(tx_data_out_q)) else $error("state moved while clock enable low");

   c_user_mode: cover property (gen_mode == MODE_USER && idx_q == 6'h3f);
   c_chk_prbs31: cover property (sel_q[CHK_MODE_LSB +: 3] == MODE_PRBS31 && chk_stat.synced);
endmodule

/* sim/tpg_link_model.sv */
/*
 * model of the serial transmit data path around the test pattern block.
 * assumes one bit per ref_clk cycle; the loopback flips a bit only on command.
 */
`timescale 1ns/1ps
module tpg_link_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // transmit side
   input wire logic tx_out,
   input wire logic flip,
   output logic tx_in,
   output logic rx_bit
);
   logic [7:0] cnt_q;

   // upstream bits change shortly after each rising edge
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= #1 cnt_q + 8'h01;
      end
   end
   assign tx_in = cnt_q[0] ^ cnt_q[3];
   // loopback to the checker input
   assign rx_bit = tx_out ^ flip;
endmodule

/* sim/tb_top.sv */
/*
 * testbench for the transmit test pattern block: registers, generator, checker.
 * assumes tpg_link_model loops the transmit bit back into the checker.
 */
`timescale 1ns/1ps
module tb_top import tpg_pkg::*;;
   localparam logic [63:0] UPW = 64'h0123_4567_89ab_cdef;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic flip = 1'b0;
   logic prev;
   tpg_reg_req_s reg_req = '0;
   logic [7:0] reg_rdata_q;
   logic tx_data_in;
   logic tx_data_out_q;
   logic chk_data_in;
   tpg_chk_stat_s chk_stat;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int loss_n = 0;
   int err_n = 0;
   // sel, cfg, status mid, status end, status mask, flips
   logic [31:0] cases [10] = '{32'h1100_8ef4, 32'h1104_8af4, 32'h2204_88f0,
      32'h3300_88f0, 32'h9900_88f0, 32'h9100_00f0, 32'h0000_00f0,
      32'h1101_1174, 32'h1106_8374, 32'h1103_88f0};

   always #12.5 ref_clk = ~ref_clk;

   tpg_top #(.LEN1(41'd64), .LEN2(41'd600), .LEN3(41'd2000)) uut (
      .ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_req(reg_req),
      .reg_rdata_q(reg_rdata_q), .user_pattern_word(UPW), .tx_data_in(tx_data_in),
      .tx_data_out_q(tx_data_out_q), .chk_data_in(chk_data_in), .chk_stat(chk_stat));

   tpg_link_model link (.ref_clk(ref_clk), .rst(rst), .tx_out(tx_data_out_q),
      .flip(flip), .tx_in(tx_data_in), .rx_bit(chk_data_in));

   always @(posedge ref_clk) begin
      cycles++;
      if (chk_stat.sync_loss === 1'b1) loss_n++;
      if (chk_stat.error === 1'b1) err_n++;
      if (cycles == 20000) begin
         num_errors++;
         results();
      end
   end

   task automatic results;
      if (num_errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("BAD %0t got %h exp %h", $time, got, exp);
         num_errors++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk) #1;
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk) #1;
      reg_req.wr = 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk) #1;
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk) #1;
      reg_req.rd = 1'b0;
      chk(reg_rdata_q, exp);
   endtask

   // each output bit must follow from the earlier ones by the sequence taps
   task automatic gen_chk(input int a, input int b, input logic inv);
      logic [63:0] h;
      h = '0;
      repeat (4) @(negedge ref_clk);
      for (int i = 0; i < 64 + a; i++) begin
         @(negedge ref_clk);
         h = {h[62:0], tx_data_out_q};
         if (i >= a) chk(h[0], h[a] ^ h[b] ^ inv);
      end
   endtask

   // 64 received bits must be some rotation of the pattern sent lsb first
   task automatic user_chk(input logic inv);
      logic [63:0] w;
      logic hit;
      hit = 1'b0;
      repeat (4) @(negedge ref_clk);
      for (int i = 0; i < 64; i++) begin
         @(negedge ref_clk);
         w[i] = tx_data_out_q;
      end
      for (int k = 0; k < 64; k++) begin
         if (w === (((UPW >> k) | (UPW << (64 - k))) ^ {64{inv}})) hit = 1'b1;
      end
      chk(hit, 1'b1);
   endtask

   task automatic chk_case(input logic [31:0] c);
      wr(SEL_ADDR, c[31:24]);
      wr(CFG_ADDR, c[23:16]);
      loss_n = 0;
      err_n = 0;
      repeat (300) @(negedge ref_clk);
      chk({chk_stat.synced, loss_n != 0, err_n != 0, chk_stat.done} & c[7:4],
         c[15:12] & c[7:4]);
      repeat (c[3:0]) begin
         @(posedge ref_clk) #1 flip = 1'b1;
         @(posedge ref_clk) #1 flip = 1'b0;
      end
      repeat (700) @(negedge ref_clk);
      chk({chk_stat.synced, loss_n != 0, err_n != 0, chk_stat.done} & c[7:4],
         c[11:8] & c[7:4]);
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      #1 rst = 1'b0;
      rd_chk(CFG_ADDR, CFG_RESET);
      rd_chk(SEL_ADDR, SEL_RESET);
      wr(CFG_ADDR, 8'hff);
      rd_chk(CFG_ADDR, 8'h07);
      wr(SEL_ADDR, 8'ha5);
      rd_chk(SEL_ADDR, 8'ha5);
      rd_chk(8'h9f, 8'h00);
      @(posedge ref_clk) #1 ce = 1'b0;
      wr(SEL_ADDR, 8'h5a);
      @(posedge ref_clk) #1 ce = 1'b1;
      rd_chk(SEL_ADDR, 8'ha5);
      wr(SEL_ADDR, 8'h00);
      repeat (2) @(negedge ref_clk);
      for (int i = 0; i < 20; i++) begin
         prev = tx_data_in;
         @(negedge ref_clk);
         chk(tx_data_out_q, prev);
      end
      wr(SEL_ADDR, 8'h01);
      gen_chk(7, 6, 1'b0);
      wr(SEL_ADDR, 8'h09);
      gen_chk(7, 6, 1'b1);
      wr(SEL_ADDR, 8'h02);
      gen_chk(31, 28, 1'b1);
      wr(SEL_ADDR, 8'h0a);
      gen_chk(31, 28, 1'b0);
      wr(SEL_ADDR, 8'h00);
      wr(SEL_ADDR, 8'h01);
      gen_chk(7, 6, 1'b0);
      wr(SEL_ADDR, 8'h03);
      user_chk(1'b0);
      wr(SEL_ADDR, 8'h0b);
      user_chk(1'b1);
      foreach (cases[i]) chk_case(cases[i]);
      results();
   end
endmodule
